// ==== hw/dacrb_pkg.sv ====
// constants, field layouts and carrier types of the serial dac register bank
package dacrb_pkg;

  // address byte values of a 24-bit frame
  localparam logic [7:0] DACRB_ADDR_NOOP = 8'h00; // no_operation_frame
  localparam logic [7:0] DACRB_ADDR_CODE = 8'h01; // output_code register
  localparam logic [7:0] DACRB_ADDR_READSEL = 8'h02; // readback select
  localparam logic [7:0] DACRB_ADDR_CONFIG = 8'h55; // output_configuration register
  localparam logic [7:0] DACRB_ADDR_RESET = 8'h56; // soft_reset register

  // readback select codes, payload bits 1:0
  localparam logic [1:0] DACRB_RSEL_STATUS = 2'h0;
  localparam logic [1:0] DACRB_RSEL_CODE = 2'h1;
  localparam logic [1:0] DACRB_RSEL_CONFIG = 2'h2;

  // frame framing
  localparam int DACRB_FRAME_BITS = 24;
  localparam logic [4:0] DACRB_BIT_LAST = 5'h17; // 24th rising edge index
  localparam logic [4:0] DACRB_BIT_FIRST = 5'h00;

  // field positions
  localparam int DACRB_RESET_BIT = 0; // only meaningful bit of soft_reset
  localparam int DACRB_ST_LOOP_FAULT_BIT = 2; // loop_current_fault
  localparam int DACRB_ST_SLEW_BIT = 1; // slewing
  localparam int DACRB_ST_TEMP_BIT = 0; // thermal alarm

  // resolution of the variant, 16 or 12
  localparam int DACRB_BITS_16 = 16;
  localparam int DACRB_BITS_12 = 12;
  localparam logic [15:0] DACRB_CODE12_MASK = 16'hFFF0; // low nibble dropped

  // values after reset
  localparam logic [15:0] DACRB_CODE_RESET = 16'h0000;
  localparam logic [15:0] DACRB_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] DACRB_STATUS_RESET = 16'h0000;
  localparam logic [23:0] DACRB_SHIFT_RESET = 24'h000000;

  // range_select codes
  localparam logic [2:0] DACRB_RANGE_V0_5 = 3'h0;
  localparam logic [2:0] DACRB_RANGE_V0_10 = 3'h1;
  localparam logic [2:0] DACRB_RANGE_VPM5 = 3'h2;
  localparam logic [2:0] DACRB_RANGE_VPM10 = 3'h3;
  localparam logic [2:0] DACRB_RANGE_NONE = 3'h4;
  localparam logic [2:0] DACRB_RANGE_I4_20 = 3'h5;
  localparam logic [2:0] DACRB_RANGE_I0_20 = 3'h6;
  localparam logic [2:0] DACRB_RANGE_I0_24 = 3'h7;

  // output_configuration layout, msb first
  typedef struct packed {
    logic clear_value_select; // bit 15
    logic overrange_enable; // bit 14
    logic external_resistor_select; // bit 13
    logic output_enable_bit; // bit 12
    logic [3:0] slew_clock_field; // bits 11:8
    logic [2:0] slew_step_field; // bits 7:5
    logic slew_limit_enable; // bit 4
    logic chain_mode_enable; // bit 3
    logic [2:0] range_select; // bits 2:0
  } dacrb_cfg_t;

  // one input frame
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] payload;
  } dacrb_frame_t;

  // readback output state
  typedef enum logic {DACRB_RB_IDLE, DACRB_RB_SHIFT} dacrb_rb_state_t;

endpackage : dacrb_pkg

// ==== hw/dacrb_sync.sv ====
// two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/10ps
module dacrb_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  logic [W-1:0] meta_reg; // first stage, read only by the second
  logic [W-1:0] sync_reg; // second stage, safe level
  logic [W-1:0] prev_reg; // delayed level for edges

  // capture chain
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~prev_reg;
  assign fall_o = ~sync_reg & prev_reg;

endmodule : dacrb_sync

// ==== hw/dacrb_bank.sv ====
// register bank of a serial-input dac with voltage and current outputs
//
// Contract
// - address 0x01 writes the output code
// - 12-bit variant keeps D15..D4, drops D3..D0
// - 16-bit variant keeps D15..D0
// - address 0x55 writes all configuration bits
// - configuration top bits: clear, overrange, resistor, enable
// - low bits: slew clock, step, enables, range
// - overrange widens voltage range by ten percent
// - outputs off unless enabled; range picks output
// - range codes map voltage and current ranges
// - address 0x56 writes reset, only D0 counts
// - reset bit one restores power-on state
// - status register is read-only
// - loop current fault bit follows pin fault
// - slewing bit set while limited ramp runs
// - thermal alarm bit follows temperature detector
// - power-on loads zero, both outputs off
// - address 0x02 selects readback, next frame shifts
// - clear select is pin OR configuration bit
// - chain mode passes bits past 24th out
`timescale 1ns/10ps
module dacrb_bank #(
  parameter int DAC_BITS = dacrb_pkg::DACRB_BITS_16 // 16 or 12
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic sclk_i,
  input wire logic sdin_i,
  input wire logic frame_latch_i,
  input wire logic clear_select_i,
  input wire logic loop_fault_i,
  input wire logic over_temp_i,
  input wire logic slew_ramping_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic [15:0] output_code_o,
  output logic [2:0] range_select_o,
  output logic vout_enable_o,
  output logic iout_enable_o,
  output logic overrange_o,
  output logic external_resistor_o,
  output logic slew_limit_enable_o,
  output logic [3:0] slew_clock_o,
  output logic [2:0] slew_step_o,
  output logic clear_value_select_o,
  output logic clear_midscale_o,
  output logic [15:0] fault_status_o
);

  // pin samples, all through two flops
  logic [6:0] pin_async; // raw pins
  logic [6:0] pin_level; // synchronised levels
  logic [6:0] pin_rise; // rising edges
  logic [6:0] pin_fall; // falling edges
  logic sclk_rise; // serial clock rising
  logic sclk_fall; // serial clock falling
  logic latch_rise; // frame strobe rising
  logic sdin_s; // serial data level
  logic clear_pin_s; // clear select pin level
  logic loop_fault_s; // current output fault level
  logic over_temp_s; // temperature detector level
  logic slew_ramp_s; // slew engine busy level

  // register state
  logic [15:0] code_reg; // output code register
  dacrb_pkg::dacrb_cfg_t cfg_reg; // configuration register
  logic [15:0] status_reg; // status register
  logic soft_rst_reg; // one-cycle full reset request
  logic rst_all; // power-on or soft reset

  // serial framing state
  logic [23:0] shift_reg; // input shift register
  logic [4:0] bit_cnt_reg; // rising edges modulo 24
  logic full_reg; // at least 24 edges seen
  logic over_reg; // more than 24 edges seen
  logic frame_ok; // frame may be latched
  dacrb_pkg::dacrb_frame_t frame; // frame view of shift register

  // readback state
  dacrb_pkg::dacrb_rb_state_t rb_state_reg; // readback phase
  logic [23:0] rb_shift_reg; // readback word under way out
  logic [15:0] rb_value; // selected register value

  // output next values
  logic vout_next; // voltage output would be live
  logic iout_next; // current output would be live
  logic clear_sel_next; // effective clear select
  logic [15:0] status_next; // status from live detectors

  // true for voltage ranges 000..011
  function automatic logic dacrb_is_voltage(input logic [2:0] range);
    dacrb_is_voltage = (range == dacrb_pkg::DACRB_RANGE_V0_5) ||
                       (range == dacrb_pkg::DACRB_RANGE_V0_10) ||
                       (range == dacrb_pkg::DACRB_RANGE_VPM5) ||
                       (range == dacrb_pkg::DACRB_RANGE_VPM10);
  endfunction : dacrb_is_voltage

  // true for current ranges 101..111
  function automatic logic dacrb_is_current(input logic [2:0] range);
    dacrb_is_current = (range == dacrb_pkg::DACRB_RANGE_I4_20) ||
                       (range == dacrb_pkg::DACRB_RANGE_I0_20) ||
                       (range == dacrb_pkg::DACRB_RANGE_I0_24);
  endfunction : dacrb_is_current

  // true for unipolar voltage ranges
  function automatic logic dacrb_is_unipolar(input logic [2:0] range);
    dacrb_is_unipolar = (range == dacrb_pkg::DACRB_RANGE_V0_5) ||
                        (range == dacrb_pkg::DACRB_RANGE_V0_10);
  endfunction : dacrb_is_unipolar

  // pin synchroniser, one instance for all pins
  assign pin_async = {slew_ramping_i, over_temp_i, loop_fault_i, clear_select_i,
                      frame_latch_i, sdin_i, sclk_i};

  dacrb_sync #(
    .W(7)
  ) u_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i(pin_async),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign sclk_rise = pin_rise[0];
  assign sclk_fall = pin_fall[0];
  assign sdin_s = pin_level[1];
  assign latch_rise = pin_rise[2];
  assign clear_pin_s = pin_level[3];
  assign loop_fault_s = pin_level[4];
  assign over_temp_s = pin_level[5];
  assign slew_ramp_s = pin_level[6];

  // power-on and soft reset act alike on all bank state except the pin synchroniser, which only nrst clears
  assign rst_all = !nrst_i || soft_rst_reg;

  // frame view and acceptance: exactly 24 edges, or multiples in chain mode
  assign frame = dacrb_pkg::dacrb_frame_t'(shift_reg);
  assign frame_ok = full_reg && (bit_cnt_reg == dacrb_pkg::DACRB_BIT_FIRST) &&
                    (!over_reg || cfg_reg.chain_mode_enable);

  // input shift register, msb first on each sclk rise
  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      shift_reg <= dacrb_pkg::DACRB_SHIFT_RESET;
    end
    else if (sclk_rise)
    begin
      shift_reg <= {shift_reg[22:0], sdin_s};
    end
  end

  // edge counter, restarted by each frame strobe
  always_ff @(posedge mclk_i)
  begin
    if (rst_all || latch_rise)
    begin
      bit_cnt_reg <= dacrb_pkg::DACRB_BIT_FIRST;
      full_reg <= 1'b0;
      over_reg <= 1'b0;
    end
    else if (sclk_rise)
    begin
      // a short frame, or a long one other than a chain-mode multiple of 24, is kept from writing anything
      if (full_reg)
      begin
        over_reg <= 1'b1;
      end
      if (bit_cnt_reg == dacrb_pkg::DACRB_BIT_LAST)
      begin
        bit_cnt_reg <= dacrb_pkg::DACRB_BIT_FIRST;
        full_reg <= 1'b1;
      end
      else
      begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // output code register
  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      code_reg <= dacrb_pkg::DACRB_CODE_RESET;
    end
    else if (latch_rise && frame_ok && frame.addr == dacrb_pkg::DACRB_ADDR_CODE)
    begin
      if (DAC_BITS == dacrb_pkg::DACRB_BITS_12)
      begin
        code_reg <= frame.payload & dacrb_pkg::DACRB_CODE12_MASK;
      end
      else
      begin
        code_reg <= frame.payload;
      end
    end
  end

  // configuration register; whole word taken, layout by struct
  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      cfg_reg <= dacrb_pkg::dacrb_cfg_t'(dacrb_pkg::DACRB_CONFIG_RESET);
    end
    else if (latch_rise && frame_ok && frame.addr == dacrb_pkg::DACRB_ADDR_CONFIG)
    begin
      // resistor select ordering is the host's duty, not checked here
      cfg_reg <= dacrb_pkg::dacrb_cfg_t'(frame.payload);
    end
  end

  // soft reset request, held one cycle; it clears itself, or nrst clears it
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i || soft_rst_reg)
    begin
      soft_rst_reg <= 1'b0;
    end
    else if (latch_rise && frame_ok && frame.addr == dacrb_pkg::DACRB_ADDR_RESET)
    begin
      soft_rst_reg <= frame.payload[dacrb_pkg::DACRB_RESET_BIT];
    end
  end

  // status from detectors; no host path writes it
  always_comb
  begin
    status_next = dacrb_pkg::DACRB_STATUS_RESET;
    status_next[dacrb_pkg::DACRB_ST_LOOP_FAULT_BIT] = loop_fault_s;
    status_next[dacrb_pkg::DACRB_ST_SLEW_BIT] = slew_ramp_s && cfg_reg.slew_limit_enable;
    status_next[dacrb_pkg::DACRB_ST_TEMP_BIT] = over_temp_s;
  end

  // status register, live levels
  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      status_reg <= dacrb_pkg::DACRB_STATUS_RESET;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  // readback source select
  always_comb
  begin
    case (frame.payload[1:0])
      dacrb_pkg::DACRB_RSEL_STATUS: rb_value = status_reg;
      dacrb_pkg::DACRB_RSEL_CODE: rb_value = code_reg;
      dacrb_pkg::DACRB_RSEL_CONFIG: rb_value = cfg_reg;
      default: rb_value = 16'h0000; // unassigned select reads zero
    endcase
  end

  // readback phase: armed by a read frame, ended by the next strobe of any other frame
  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      rb_state_reg <= dacrb_pkg::DACRB_RB_IDLE;
      rb_shift_reg <= dacrb_pkg::DACRB_SHIFT_RESET;
    end
    else
    begin
      case (rb_state_reg)
        dacrb_pkg::DACRB_RB_IDLE:
        begin
          if (latch_rise && frame_ok && frame.addr == dacrb_pkg::DACRB_ADDR_READSEL)
          begin
            rb_state_reg <= dacrb_pkg::DACRB_RB_SHIFT;
            rb_shift_reg <= {8'h00, rb_value};
          end
        end
        dacrb_pkg::DACRB_RB_SHIFT:
        begin
          if (latch_rise)
          begin
            // a back-to-back read frame re-arms with fresh data
            if (frame_ok && frame.addr == dacrb_pkg::DACRB_ADDR_READSEL)
            begin
              rb_shift_reg <= {8'h00, rb_value};
            end
            else
            begin
              rb_state_reg <= dacrb_pkg::DACRB_RB_IDLE;
            end
          end
          else if (sclk_fall)
          begin
            rb_shift_reg <= {rb_shift_reg[22:0], 1'b0};
          end
        end
        default:
        begin
          rb_state_reg <= dacrb_pkg::DACRB_RB_IDLE;
        end
      endcase
    end
  end

  // serial output pin; chain data or readback, moved on sclk fall
  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end
    else if (rb_state_reg == dacrb_pkg::DACRB_RB_SHIFT)
    begin
      sdo_oe_o <= 1'b1;
      // msb must stand before the first rise, so it follows the shift word
      sdo_o <= rb_shift_reg[23];
    end
    else if (cfg_reg.chain_mode_enable)
    begin
      sdo_oe_o <= 1'b1;
      if (sclk_fall)
      begin
        sdo_o <= shift_reg[23];
      end
    end
    else
    begin
      sdo_oe_o <= 1'b0;
      sdo_o <= 1'b0;
    end
  end

  // output selection from enable and range
  assign vout_next = cfg_reg.output_enable_bit && dacrb_is_voltage(cfg_reg.range_select);
  assign iout_next = cfg_reg.output_enable_bit && dacrb_is_current(cfg_reg.range_select);
  assign clear_sel_next = cfg_reg.clear_value_select || clear_pin_s;

  // registered analog controls
  always_ff @(posedge mclk_i)
  begin
    if (rst_all)
    begin
      vout_enable_o <= 1'b0;
      iout_enable_o <= 1'b0;
      output_code_o <= dacrb_pkg::DACRB_CODE_RESET;
      range_select_o <= dacrb_pkg::DACRB_RANGE_V0_5;
      overrange_o <= 1'b0;
      external_resistor_o <= 1'b0;
      slew_limit_enable_o <= 1'b0;
      slew_clock_o <= 4'h0;
      slew_step_o <= 3'h0;
      clear_value_select_o <= 1'b0;
      clear_midscale_o <= 1'b0;
      fault_status_o <= dacrb_pkg::DACRB_STATUS_RESET;
    end
    else
    begin
      vout_enable_o <= vout_next;
      iout_enable_o <= iout_next;
      output_code_o <= code_reg;
      range_select_o <= cfg_reg.range_select;
      // overrange only has meaning on the voltage output
      overrange_o <= cfg_reg.overrange_enable && vout_next;
      external_resistor_o <= cfg_reg.external_resistor_select;
      slew_limit_enable_o <= cfg_reg.slew_limit_enable;
      slew_clock_o <= cfg_reg.slew_clock_field;
      slew_step_o <= cfg_reg.slew_step_field;
      clear_value_select_o <= clear_sel_next;
      // bipolar ranges clear to zero scale, which is 0 V
      clear_midscale_o <= clear_sel_next && dacrb_is_unipolar(cfg_reg.range_select);
      fault_status_o <= status_reg;
    end
  end

endmodule : dacrb_bank

// ==== tb/dacrb_bank_props.sv ====
// concurrent checks on the ports of the dac register bank
`timescale 1ns/10ps
module dacrb_bank_props (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic frame_latch_i,
  input wire logic clear_select_i,
  input wire logic loop_fault_i,
  input wire logic over_temp_i,
  input wire logic sdo_oe_o,
  input wire logic [15:0] output_code_o,
  input wire logic [2:0] range_select_o,
  input wire logic vout_enable_o,
  input wire logic iout_enable_o,
  input wire logic overrange_o,
  input wire logic slew_limit_enable_o,
  input wire logic clear_value_select_o,
  input wire logic clear_midscale_o,
  input wire logic [15:0] fault_status_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic latch_prev_reg; // strobe pin one edge ago
  logic [3:0] since_latch_reg; // edges since strobe rise, saturating
  // age of the last strobe; updates must land a few edges after it
  always_ff @(posedge mclk_i)
  begin
    latch_prev_reg <= frame_latch_i;
    if (!nrst_i)
      since_latch_reg <= 4'hF;
    else if (frame_latch_i && !latch_prev_reg)
      since_latch_reg <= 4'h0;
    else if (since_latch_reg != 4'hF)
      since_latch_reg <= since_latch_reg + 4'h1;
  end
  // five samples leave room for the two synchroniser flops and the status_reg and fault_status_o stages
  sequence s_hot;
    over_temp_i [*5];
  endsequence
  sequence s_open_loop;
    loop_fault_i [*5];
  endsequence
  a_release_zero: assert property ($rose(nrst_i) |-> output_code_o == 16'h0000 && fault_status_o == 16'h0000
    && !vout_enable_o && !iout_enable_o && !sdo_oe_o) else $error("outputs not clear after reset");
  a_one_output: assert property (!(vout_enable_o && iout_enable_o))
    else $error("both outputs enabled");
  a_vout_range: assert property (vout_enable_o |-> range_select_o <= 3'h3)
    else $error("voltage output on a current range");
  a_iout_range: assert property (iout_enable_o |-> range_select_o >= 3'h5)
    else $error("current output on a voltage or empty range");
  a_over_gate: assert property (overrange_o |-> vout_enable_o)
    else $error("overrange without voltage output");
  a_mid_scale: assert property (clear_midscale_o == (clear_value_select_o && range_select_o <= 3'h1))
    else $error("midscale clear mismatch");
  a_clear_pin: assert property (clear_select_i [*5] |-> clear_value_select_o)
    else $error("clear select pin ignored");
  a_temp_status: assert property (s_hot |-> fault_status_o[dacrb_pkg::DACRB_ST_TEMP_BIT])
    else $error("thermal alarm bit missing");
  a_loop_fault: assert property (s_open_loop |-> fault_status_o[dacrb_pkg::DACRB_ST_LOOP_FAULT_BIT])
    else $error("loop current fault bit missing");
  a_slew_gate: assert property (fault_status_o[1] |-> slew_limit_enable_o || $past(slew_limit_enable_o))
    else $error("slewing bit without slew limit");
  a_code_timing: assert property ($changed(output_code_o) |-> since_latch_reg >= 4'h2 && since_latch_reg <= 4'h8)
    else $error("output code changed away from a strobe");
  a_sdo_timing: assert property ($changed(sdo_oe_o) |-> since_latch_reg >= 4'h2 && since_latch_reg <= 4'h8)
    else $error("serial output enable moved away from a strobe");
endmodule : dacrb_bank_props
bind dacrb_bank dacrb_bank_props u_props (.mclk_i(mclk_i), .nrst_i(nrst_i), .frame_latch_i(frame_latch_i),
  .clear_select_i(clear_select_i), .loop_fault_i(loop_fault_i), .over_temp_i(over_temp_i), .sdo_oe_o(sdo_oe_o),
  .output_code_o(output_code_o), .range_select_o(range_select_o), .vout_enable_o(vout_enable_o),
  .iout_enable_o(iout_enable_o), .overrange_o(overrange_o), .slew_limit_enable_o(slew_limit_enable_o),
  .clear_value_select_o(clear_value_select_o), .clear_midscale_o(clear_midscale_o), .fault_status_o(fault_status_o));

// ==== tb/dacrb_host_model.sv ====
// serial host that frames writes and shifts readback in
`timescale 1ns/10ps
module dacrb_host_model (
  output logic sclk_o,
  output logic sdin_o,
  output logic latch_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  // serial clock stands still low between frames
  initial
  begin
    sclk_o = 1'b0;
    sdin_o = 1'b0;
    latch_o = 1'b0;
  end
  // nbits msb first at 200 ns a bit; sdo read just before each fall
  task automatic send(input logic [31:0] bits, input int nbits, output logic [23:0] rx);
    rx = 24'h000000;
    #7;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sdin_o = bits[i];
      #100 sclk_o = 1'b1;
      #100 rx = {rx[22:0], sdo_oe_i ? sdo_i : 1'bx};
      sclk_o = 1'b0;
    end
    sdin_o = ~sdin_o; // released line keeps no stale bit
    #100 latch_o = 1'b1; // strobe only after the last rise
    #200 latch_o = 1'b0;
    #300;
  endtask : send
endmodule : dacrb_host_model

// ==== tb/test_dacrb_bank.sv ====
// self-checking bench of the serial dac register bank
`timescale 1ns/10ps
module test_dacrb_bank;
  typedef struct packed {logic [2:0] kind; logic [31:0] value;} dacrb_note_t;
  localparam logic [2:0] k_code = 3'h0, k_code12 = 3'h1, k_outs = 3'h2, k_stat = 3'h3, k_rb = 3'h4;
  logic mclk_i, nrst_i, clear_select_i, loop_fault_i, over_temp_i, slew_ramping_i, chk;
  logic sclk, sdin, latch, sdo, sdo_oe, vout_en, iout_en, over, res_ext, slew_en, clr, mid;
  logic [15:0] code, code12, status, v;
  logic [2:0] range, step;
  logic [3:0] slew_clk;
  logic [23:0] rx;
  logic [31:0] got, seed;
  dacrb_pkg::dacrb_cfg_t c;
  dacrb_note_t notes[$]; // expected results, oldest first
  int n_mismatch = 0;
  int n_compared = 0;
  string names[5] = '{"code", "code12", "outputs", "status", "readback"};
  always #12.5 mclk_i = ~mclk_i;
  dacrb_host_model u_host (.sclk_o(sclk), .sdin_o(sdin), .latch_o(latch), .sdo_i(sdo), .sdo_oe_i(sdo_oe));
  dacrb_bank DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(sclk), .sdin_i(sdin), .frame_latch_i(latch),
    .clear_select_i(clear_select_i), .loop_fault_i(loop_fault_i), .over_temp_i(over_temp_i),
    .slew_ramping_i(slew_ramping_i), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .output_code_o(code), .range_select_o(range),
    .vout_enable_o(vout_en), .iout_enable_o(iout_en), .overrange_o(over), .external_resistor_o(res_ext),
    .slew_limit_enable_o(slew_en), .slew_clock_o(slew_clk), .slew_step_o(step), .clear_value_select_o(clr),
    .clear_midscale_o(mid), .fault_status_o(status));
  // 12-bit variant on the same pins, only its code is watched
  dacrb_bank #(.DAC_BITS(dacrb_pkg::DACRB_BITS_12)) DUT_12 (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(sclk),
    .sdin_i(sdin), .frame_latch_i(latch), .clear_select_i(clear_select_i), .loop_fault_i(loop_fault_i),
    .over_temp_i(over_temp_i), .slew_ramping_i(slew_ramping_i), .sdo_o(), .sdo_oe_o(), .output_code_o(code12),
    .range_select_o(), .vout_enable_o(), .iout_enable_o(), .overrange_o(), .external_resistor_o(),
    .slew_limit_enable_o(), .slew_clock_o(), .slew_step_o(), .clear_value_select_o(), .clear_midscale_o(),
    .fault_status_o());
  // pick the observed value for a note kind
  function automatic logic [31:0] observe(input logic [2:0] k);
    case (k)
      k_code: observe = {16'h0000, code};
      k_code12: observe = {16'h0000, code12};
      k_outs: observe = {15'h0, vout_en, iout_en, over, res_ext, slew_en, slew_clk, step, range, clr, mid};
      k_stat: observe = {16'h0000, status};
      default: observe = {8'h00, rx};
    endcase
  endfunction : observe
  // output pins expected from a configuration word and the clear pin
  function automatic logic [31:0] exp_outs(input dacrb_pkg::dacrb_cfg_t f, input logic p);
    logic vo, io, s;
    vo = f.output_enable_bit && f.range_select <= 3'h3;
    io = f.output_enable_bit && f.range_select >= 3'h5;
    s = f.clear_value_select | p;
    exp_outs = {15'h0, vo, io, f.overrange_enable & vo, f.external_resistor_select, f.slew_limit_enable,
      f.slew_clock_field, f.slew_step_field, f.range_select, s, s & (f.range_select <= 3'h1)};
  endfunction : exp_outs
  // note an expectation, then ask the watcher to compare
  task automatic expect_val(input logic [2:0] k, input logic [31:0] e);
    notes.push_back('{k, e});
    @(posedge mclk_i);
    chk <= 1'b1;
    @(posedge mclk_i);
    chk <= 1'b0;
  endtask : expect_val
  // one whole 24-bit frame
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    u_host.send({8'h00, a, d}, 24, rx);
  endtask : wr
  // select a register, then shift it out with an empty frame
  task automatic rd(input logic [1:0] s, input logic [31:0] e);
    wr(dacrb_pkg::DACRB_ADDR_READSEL, {14'h0, s});
    wr(dacrb_pkg::DACRB_ADDR_NOOP, 16'h0000);
    expect_val(k_rb, e);
  endtask : rd
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // watcher: oldest note against the outputs
  always @(posedge mclk_i)
  begin
    if (chk === 1'b1)
    begin
      got = observe(notes[0].kind);
      n_compared++;
      if (got !== notes[0].value)
      begin
        $display("unexpected %s expected %h seen %h", names[notes[0].kind], notes[0].value, got);
        n_mismatch++;
      end
      void'(notes.pop_front());
    end
  end
  // hang guard
  initial
  begin
    repeat (100000) @(posedge mclk_i);
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    {mclk_i, nrst_i, clear_select_i, loop_fault_i, over_temp_i, slew_ramping_i, chk} = 7'h00;
    seed = $urandom(32'h365E);
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    expect_val(k_code, 32'h0);
    expect_val(k_outs, 32'h0);
    expect_val(k_stat, 32'h0);
    // boundary codes then a random one
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 3) ? 16'($urandom) : ((i == 0) ? 16'hFFFF : ((i == 1) ? 16'h000F : 16'h8001));
      wr(dacrb_pkg::DACRB_ADDR_CODE, v);
      expect_val(k_code, {16'h0000, v});
      expect_val(k_code12, {16'h0000, v & dacrb_pkg::DACRB_CODE12_MASK});
    end
    // every range code, enabled and disabled
    for (int i = 0; i < 16; i++)
    begin
      c = 16'($urandom);
      c.range_select = 3'(i);
      c.output_enable_bit = (i < 8);
      c.chain_mode_enable = 1'b0;
      c.external_resistor_select &= c.output_enable_bit;
      @(posedge mclk_i);
      clear_select_i <= 1'($urandom);
      wr(dacrb_pkg::DACRB_ADDR_CONFIG, c);
      expect_val(k_outs, exp_outs(c, clear_select_i));
      rd(dacrb_pkg::DACRB_RSEL_CONFIG, {16'h0000, c});
    end
    rd(dacrb_pkg::DACRB_RSEL_CODE, {16'h0000, v});
    @(posedge mclk_i);
    {loop_fault_i, over_temp_i, slew_ramping_i, clear_select_i} <= 4'hE;
    wr(dacrb_pkg::DACRB_ADDR_CONFIG, 16'h0010);
    expect_val(k_stat, 32'h7);
    rd(dacrb_pkg::DACRB_RSEL_STATUS, 32'h7);
    wr(dacrb_pkg::DACRB_ADDR_CONFIG, 16'h0000);
    expect_val(k_stat, 32'h5);
    wr(8'h03, 16'hFFFF);
    expect_val(k_stat, 32'h5);
    expect_val(k_code, {16'h0000, v});
    rd(2'h3, 32'h0);
    @(posedge mclk_i);
    {loop_fault_i, over_temp_i, slew_ramping_i} <= 3'h0;
    repeat (8) @(posedge mclk_i);
    expect_val(k_stat, 32'h0);
    // short and long frames are dropped
    for (int n = 23; n <= 25; n += 2)
    begin
      @(posedge mclk_i);
      u_host.send({16'h0001, 16'h1234}, n, rx);
    end
    expect_val(k_code, {16'h0000, v});
    // chain mode: the next frame pushes the previous one out on sdo
    wr(dacrb_pkg::DACRB_ADDR_CONFIG, 16'h0008);
    wr(dacrb_pkg::DACRB_ADDR_CODE, 16'h5A5A);
    wr(dacrb_pkg::DACRB_ADDR_NOOP, 16'h0000);
    expect_val(k_rb, 32'h00015A5A);
    wr(dacrb_pkg::DACRB_ADDR_CONFIG, 16'h1005);
    wr(dacrb_pkg::DACRB_ADDR_CODE, 16'hA5A5);
    wr(dacrb_pkg::DACRB_ADDR_RESET, 16'hFFFE);
    expect_val(k_code, 32'hA5A5);
    expect_val(k_outs, exp_outs(16'h1005, 1'b0));
    wr(dacrb_pkg::DACRB_ADDR_RESET, 16'h0001);
    expect_val(k_code, 32'h0);
    expect_val(k_outs, 32'h0);
    rd(dacrb_pkg::DACRB_RSEL_CONFIG, 32'h0);
    finish_test();
  end
endmodule : test_dacrb_bank
